// ---- pkg/byte_op_exec_regs.vh ----
/*
 * Register offsets, field positions, opcodes and reset values of the
 * byte-operation and branch execution block.
 * Assumes inclusion by bare name from the design files of that block.
 */
`ifndef BYTE_OP_EXEC_REGS_VH
`define BYTE_OP_EXEC_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_INSTR        8'h00
`define OFS_ACCUM        8'h04
`define OFS_STATUS       8'h08
`define OFS_PAGE_LATCH   8'h0c
`define OFS_PROG_COUNTER 8'h10
`define OFS_FILE_ADDR    8'h14
`define OFS_FILE_DATA    8'h18
`define OFS_CYCLE_COUNT  8'h1c

// ****************************************************************
// instruction word fields
// ****************************************************************
`define OPCODE_MSB       15
`define OPCODE_LSB       12
`define DEST_BIT         7
`define FILE_MSB         6
`define FILE_LSB         0
`define LITERAL_MSB      10
`define LITERAL_LSB      0

// ****************************************************************
// status register fields
// ****************************************************************
`define STAT_ZERO        0
`define STAT_FLUSH       1
`define STAT_BUSY        2

// ****************************************************************
// page latch bits copied into the program counter
// ****************************************************************
`define PAGE_HI          4
`define PAGE_LO          3

// ****************************************************************
// opcodes
// ****************************************************************
`define OP_NOP           4'h0
`define OP_COMPLEMENT    4'h1
`define OP_CLEAR_REG     4'h2
`define OP_DECREMENT     4'h3
`define OP_CLEAR_ACC     4'h4
`define OP_DEC_SKIP      4'h5
`define OP_INC_SKIP      4'h6
`define OP_BRANCH        4'h7

// ****************************************************************
// destination select and reset values
// ****************************************************************
`define DEST_ACCUM       1'b0
`define DEST_FILE        1'b1
`define RST_ACCUM        8'h00
`define RST_STATUS_ZERO  1'b0
`define RST_PAGE_LATCH   5'h00
`define RST_PROG_COUNTER 13'h0000
`define RST_INSTR        16'h0000

// ****************************************************************
// bus responses
// ****************************************************************
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ---- hw/byte_op_alu.v ----
/*
 * Combinational decode and arithmetic for one issued instruction.
 * Assumes the caller supplies the addressed data register value and
 * commits the results on its own clock edge.
 */
`timescale 1ns/1ps
`include "byte_op_exec_regs.vh"

module byte_op_alu (
    // instruction
    input  wire [3:0] opcode,
    input  wire       destSel,
    input  wire [7:0] fileValue,
    // results
    output reg  [7:0] result,
    output reg        writeAcc,
    output reg        writeFile,
    output reg        zeroUpdate,
    output reg        zeroValue,
    output reg        skipTaken,
    output reg        branchTaken
);

    always @* begin
        result      = 8'h00;
        writeAcc    = 1'b0;
        writeFile   = 1'b0;
        zeroUpdate  = 1'b0;
        zeroValue   = 1'b0;
        skipTaken   = 1'b0;
        branchTaken = 1'b0;
        case (opcode)
            `OP_COMPLEMENT: begin
                result     = ~fileValue;
                writeAcc   = (destSel == `DEST_ACCUM);
                writeFile  = (destSel == `DEST_FILE);
                zeroUpdate = 1'b1;
                zeroValue  = (result == 8'h00);
            end
            `OP_CLEAR_REG: begin
                result     = 8'h00;
                writeFile  = 1'b1;
                zeroUpdate = 1'b1;
                zeroValue  = 1'b1;
            end
            `OP_DECREMENT: begin
                result     = fileValue - 8'h01;
                writeAcc   = (destSel == `DEST_ACCUM);
                writeFile  = (destSel == `DEST_FILE);
                zeroUpdate = 1'b1;
                zeroValue  = (result == 8'h00);
            end
            `OP_CLEAR_ACC: begin
                result     = 8'h00;
                writeAcc   = 1'b1;
                zeroUpdate = 1'b1;
                zeroValue  = 1'b1;
            end
            `OP_DEC_SKIP: begin
                result    = fileValue - 8'h01;
                writeAcc  = (destSel == `DEST_ACCUM);
                writeFile = (destSel == `DEST_FILE);
                skipTaken = (result == 8'h00);
            end
            `OP_INC_SKIP: begin
                result    = fileValue + 8'h01;
                writeAcc  = (destSel == `DEST_ACCUM);
                writeFile = (destSel == `DEST_FILE);
                skipTaken = (result == 8'h00);
            end
            `OP_BRANCH: begin
                branchTaken = 1'b1;
            end
            default: begin
                result = 8'h00;
            end
        endcase
    end

endmodule

// ---- hw/byte_op_and_branch_exec.v ----
/*
 * Execution block for complement, clear, decrement, skip-on-zero and
 * unconditional branch instructions, reached over an AXI4-Lite slave.
 * Assumes a single 25 MHz clock; software issues one instruction word
 * per write to the instruction register and plays the fetch stage.
 */
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
// Behaviour
// - complement inverts every bit of the addressed data register, address 0 to 127
// - destination bit 0 writes accumulator, 1 writes the data register back
// - clear-register writes 00h into the data register and sets zero
// - plain decrement subtracts one, routes by destination bit, updates zero
// - clear-accumulator loads 00h into accumulator and sets zero, no operand
// - decrement-and-skip subtracts one, routes by destination, flags unchanged
// - zero result discards next instruction as no-operation, two cycles
// - increment-and-skip adds one, routes by destination, flags unchanged
// - zero result replaces following instruction with no-operation, two cycles
// - branch loads 11-bit literal into program counter bits 10 to 0
// - branch copies page latch bits 4 and 3 into counter bits 12, 11
// - branch takes two cycles, flushes next fetched instruction, flags unaffected
`timescale 1ns/1ps
`include "byte_op_exec_regs.vh"

module byte_op_and_branch_exec (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    // write address channel
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // write data channel
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // write response channel
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // read address channel
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // read data channel
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ****************************************************************
    // state
    // ****************************************************************
    reg  [7:0]  dataFile [0:127];
    reg  [7:0]  accum_reg;
    reg         zeroFlag_reg;
    reg         flushPending_reg;
    reg         busy_reg;
    reg  [4:0]  pageLatch_reg;
    reg  [12:0] progCounter_reg;
    reg  [15:0] instr_reg;
    reg  [6:0]  fileAddr_reg;
    reg  [31:0] cycleCount_reg;

    // bus channel holding registers
    reg         awHeld_reg;
    reg  [7:0]  awAddr_reg;
    reg         wHeld_reg;
    reg  [31:0] wData_reg;
    reg  [3:0]  wStrb_reg;
    reg         bValid_reg;
    reg  [1:0]  bResp_reg;
    reg         rValid_reg;
    reg  [31:0] rData_reg;
    reg  [1:0]  rResp_reg;

    // ****************************************************************
    // byte-lane merge
    // ****************************************************************
    function [31:0] laneMerge;
        input [31:0] oldVal;
        input [31:0] newVal;
        input [3:0]  strb;
        integer i;
        begin
            laneMerge = oldVal;

            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    laneMerge[i*8 +: 8] = newVal[i*8 +: 8];
                end
            end
        end
    endfunction

    // ****************************************************************
    // write channel acceptance
    // ****************************************************************
    // address and data are taken independently; the pair waits out a
    // second instruction cycle so nothing lands mid-branch or mid-skip
    wire doWrite = awHeld_reg && wHeld_reg && !bValid_reg && !busy_reg;

    assign s_axi_awready = !awHeld_reg;
    assign s_axi_wready  = !wHeld_reg;
    assign s_axi_bvalid  = bValid_reg;
    assign s_axi_bresp   = bResp_reg;

    // ****************************************************************
    // write address decode
    // ****************************************************************
    wire writeMapped = (awAddr_reg == `OFS_INSTR)
                    || (awAddr_reg == `OFS_ACCUM)
                    || (awAddr_reg == `OFS_STATUS)
                    || (awAddr_reg == `OFS_PAGE_LATCH)
                    || (awAddr_reg == `OFS_PROG_COUNTER)
                    || (awAddr_reg == `OFS_FILE_ADDR)
                    || (awAddr_reg == `OFS_FILE_DATA)
                    || (awAddr_reg == `OFS_CYCLE_COUNT);

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wHeld_reg  <= 1'b0;
            wData_reg  <= 32'h00000000;
            wStrb_reg  <= 4'h0;
            bValid_reg <= 1'b0;
            bResp_reg  <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !awHeld_reg) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end

            if (s_axi_wvalid && !wHeld_reg) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end

            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg  <= 1'b0;
                bValid_reg <= 1'b1;
                // unmapped: error answer, no register changes
                bResp_reg  <= writeMapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bValid_reg && s_axi_bready) begin
                bValid_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // instruction issue
    // ****************************************************************
    // merged against the last word: a partial strobe keeps the old lanes
    wire [31:0] issueMerged = laneMerge({16'h0000, instr_reg}, wData_reg, wStrb_reg);
    wire [15:0] issueWord  = issueMerged[15:0];
    wire        issue      = doWrite && (awAddr_reg == `OFS_INSTR);
    // a flushed slot runs as a no-operation whatever was fetched
    wire [3:0]  issueOp    = flushPending_reg ? `OP_NOP
                                              : issueWord[`OPCODE_MSB:`OPCODE_LSB];
    wire [6:0]  issueFile  = issueWord[`FILE_MSB:`FILE_LSB];
    wire [7:0]  fileValue  = dataFile[issueFile];

    wire [7:0]  aluResult;
    wire        aluWriteAcc;
    wire        aluWriteFile;
    wire        aluZeroUpdate;
    wire        aluZeroValue;
    wire        aluSkip;
    wire        aluBranch;

    byte_op_alu alu (
        .opcode      (issueOp),
        .destSel     (issueWord[`DEST_BIT]),
        .fileValue   (fileValue),
        .result      (aluResult),
        .writeAcc    (aluWriteAcc),
        .writeFile   (aluWriteFile),
        .zeroUpdate  (aluZeroUpdate),
        .zeroValue   (aluZeroValue),
        .skipTaken   (aluSkip),
        .branchTaken (aluBranch)
    );

    // ****************************************************************
    // branch target
    // ****************************************************************
    // literal into low counter bits
    // page bits into high counter bits
    wire [12:0] branchTarget = {pageLatch_reg[`PAGE_HI:`PAGE_LO],
                                issueWord[`LITERAL_MSB:`LITERAL_LSB]};

    // software write lanes; unstrobed lanes read as zero
    wire [31:0] wordIn = laneMerge(32'h00000000, wData_reg, wStrb_reg);

    // counter write from software, cut back to the 13 counter bits
    wire [31:0] pcMerged = laneMerge({19'h00000, progCounter_reg}, wData_reg, wStrb_reg);

    // ****************************************************************
    // data register file
    // ****************************************************************
    // no reset on the array: it models plain data memory
    always @(posedge ref_clk) begin
        if (issue && aluWriteFile) begin
            dataFile[issueFile] <= aluResult;
        end else if (doWrite && awAddr_reg == `OFS_FILE_DATA && wStrb_reg[0]) begin
            // software load at the index held in the address register
            dataFile[fileAddr_reg] <= wData_reg[7:0];
        end
    end

    // ****************************************************************
    // core state update
    // ****************************************************************
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            accum_reg        <= `RST_ACCUM;
            zeroFlag_reg     <= `RST_STATUS_ZERO;
            flushPending_reg <= 1'b0;
            busy_reg         <= 1'b0;
            pageLatch_reg    <= `RST_PAGE_LATCH;
            progCounter_reg  <= `RST_PROG_COUNTER;
            instr_reg        <= `RST_INSTR;
            fileAddr_reg     <= 7'h00;
            cycleCount_reg   <= 32'h00000000;
        end else begin
            // busy lasts one cycle: the slot of the inserted no-operation
            busy_reg <= 1'b0;
            // that slot is an instruction cycle of its own
            if (busy_reg) begin
                cycleCount_reg <= cycleCount_reg + 32'h00000001;
            end

            if (issue) begin
                instr_reg      <= issueWord;
                cycleCount_reg <= cycleCount_reg + 32'h00000001;
                if (aluWriteAcc) begin
                    accum_reg <= aluResult;
                end

                if (aluZeroUpdate) begin
                    zeroFlag_reg <= aluZeroValue;
                end

                if (aluBranch) begin
                    progCounter_reg <= branchTarget;
                end else begin
                    progCounter_reg <= progCounter_reg + 13'h0001;
                end

                flushPending_reg <= aluSkip || aluBranch;
                busy_reg         <= aluSkip || aluBranch;
            end else if (doWrite) begin
                // 8-bit registers follow lane 0 only; other lanes are ignored
                case (awAddr_reg)
                    `OFS_ACCUM: begin
                        if (wStrb_reg[0]) begin
                            accum_reg <= wData_reg[7:0];
                        end
                    end
                    `OFS_STATUS: begin
                        if (wStrb_reg[0]) begin
                            zeroFlag_reg <= wData_reg[`STAT_ZERO];
                        end
                    end
                    `OFS_PAGE_LATCH: begin
                        pageLatch_reg <= wordIn[4:0] | (pageLatch_reg & {5{~wStrb_reg[0]}});
                    end
                    `OFS_PROG_COUNTER: begin
                        progCounter_reg <= pcMerged[12:0];
                    end
                    `OFS_FILE_ADDR: begin
                        if (wStrb_reg[0]) begin
                            fileAddr_reg <= wData_reg[6:0];
                        end
                    end
                    `OFS_CYCLE_COUNT: begin
                        // any write clears, whatever the data
                        cycleCount_reg <= 32'h00000000;
                    end
                    default: begin
                        fileAddr_reg <= fileAddr_reg;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    assign s_axi_arready = !rValid_reg;
    assign s_axi_rvalid  = rValid_reg;
    assign s_axi_rdata   = rData_reg;
    assign s_axi_rresp   = rResp_reg;

    // status bits: busy, pending flush, zero flag from the top down
    wire [31:0] statusWord = {29'h00000000, busy_reg, flushPending_reg, zeroFlag_reg};

    reg [31:0] readValue;
    reg        readMapped;

    always @* begin
        readValue  = 32'h00000000;
        readMapped = 1'b1;

        case ({s_axi_araddr[7:2], 2'b00})
            `OFS_INSTR:        readValue = {16'h0000, instr_reg};
            `OFS_ACCUM:        readValue = {24'h000000, accum_reg};
            `OFS_STATUS:       readValue = statusWord;
            `OFS_PAGE_LATCH:   readValue = {27'h0000000, pageLatch_reg};
            `OFS_PROG_COUNTER: readValue = {19'h00000, progCounter_reg};
            `OFS_FILE_ADDR:    readValue = {25'h0000000, fileAddr_reg};
            `OFS_FILE_DATA:    readValue = {24'h000000, dataFile[fileAddr_reg]};
            `OFS_CYCLE_COUNT:  readValue = cycleCount_reg;
            default:           readMapped = 1'b0;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rValid_reg <= 1'b0;
            rData_reg  <= 32'h00000000;
            rResp_reg  <= `RESP_OKAY;
        end else begin
            // registered answer: data stands unchanged while rvalid waits
            if (s_axi_arvalid && !rValid_reg) begin
                rValid_reg <= 1'b1;
                rData_reg  <= readValue;
                rResp_reg  <= readMapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rValid_reg && s_axi_rready) begin
                rValid_reg <= 1'b0;
            end
        end
    end

endmodule

// ---- dv/byte_op_exec_properties.sv ----
/*
 * Bus-side assertions for the byte-operation and branch execution block.
 * Assumes binding to that block's top-module ports, one clock domain.
 */
`timescale 1ns/1ps

module byte_op_exec_properties (
    // clock and reset
    input wire        ref_clk,
    input wire        rst_n,
    // write side
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    // read side
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // write channel
    // ****************************************************************
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    // a response still waiting on bready holds the next write back by one edge; busy has cleared before a new pair is held
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[2:3] s_axi_bvalid) else $error("write response late");
    AST_B_CAUSE: assert property ($rose(s_axi_bvalid) |->
        !$past(s_axi_awready) && !$past(s_axi_wready)) else $error("response without held write");
    AST_AW_BLOCK: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address ready while address held");
    AST_W_BLOCK: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
        else $error("data ready while data held");
    AST_B_CODE: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
        else $error("illegal write response code");

    // ****************************************************************
    // read channel
    // ****************************************************************
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped early");
    AST_AR_READY: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_ERR: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
endmodule

bind byte_op_and_branch_exec byte_op_exec_properties u_props (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ---- dv/tb_top.sv ----
/*
 * Self-checking bench: drives instruction words over the register bus.
 * Assumes the shared register map header and a 25 MHz clock.
 */
`timescale 1ns/1ps
`include "byte_op_exec_regs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module tb_top;
    logic        ref_clk;
    logic        rst_n;
    logic [7:0]  awAddr;
    logic [7:0]  arAddr;
    logic [31:0] wData;
    logic [31:0] rData;
    logic [1:0]  bResp;
    logic [1:0]  rResp;
    logic        awValid, awReady, wValid, wReady, bValid, bReady;
    logic        arValid, arReady, rValid, rReady;
    int          error_cnt = 0;
    int          n_tests = 0;
    logic [4:0]  pg [2] = '{5'h17, 5'h0f};
    logic [10:0] lit [2] = '{11'h7ff, 11'h2a5};

    byte_op_and_branch_exec u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // bus tasks
    // ****************************************************************
    // ready is looked at mid-cycle: inputs only move after rising edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = `RESP_OKAY);
        logic ta, tw, tb;
        logic [1:0] r;
        int n;
        @(posedge ref_clk);
        awAddr <= a;
        awValid <= 1'b1;
        wData <= d;
        wValid <= 1'b1;
        bReady <= 1'b1;
        tb = 1'b0;
        for (n = 0; n < 64 && !tb; n++) begin
            @(negedge ref_clk);
            ta = awValid && awReady;
            tw = wValid && wReady;
            tb = bValid === 1'b1;
            r = bResp;
            @(posedge ref_clk);
            if (ta) awValid <= 1'b0;
            if (tw) wValid <= 1'b0;
            if (tb) bReady <= 1'b0;
        end
        `CHK(tb, 1'b1)
        `CHK(r, e)
    endtask

    task automatic cr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `RESP_OKAY);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        @(posedge ref_clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        tr = 1'b0;
        for (n = 0; n < 64 && !tr; n++) begin
            @(negedge ref_clk);
            ta = arValid && arReady;
            tr = rValid === 1'b1;
            d = rData;
            r = rResp;
            @(posedge ref_clk);
            if (ta) arValid <= 1'b0;
            if (tr) rReady <= 1'b0;
        end
        `CHK(tr, 1'b1)
        `CHK(d, e)
        `CHK(r, er)
    endtask

    task automatic op(input logic [3:0] o, input logic dst, input logic [6:0] f);
        wr(`OFS_INSTR, {16'h0, o, 4'h0, dst, f});
    endtask

    task automatic setf(input logic [6:0] f, input logic [7:0] v);
        wr(`OFS_FILE_ADDR, {25'h0, f});
        wr(`OFS_FILE_DATA, {24'h0, v});
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        summarize();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        {awAddr, arAddr, wData} = '0;
        {awValid, wValid, bReady, arValid, rReady} = '0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        cr(`OFS_ACCUM, 32'h0);
        cr(`OFS_STATUS, 32'h0);
        cr(`OFS_PROG_COUNTER, 32'h0);
        cr(8'h20, 32'h0, `RESP_SLVERR);
        wr(8'h24, 32'h1, `RESP_SLVERR);
        setf(7'h7f, 8'h5a);
        op(`OP_COMPLEMENT, `DEST_ACCUM, 7'h7f);
        cr(`OFS_ACCUM, 32'ha5);
        cr(`OFS_FILE_DATA, 32'h5a);
        cr(`OFS_STATUS, 32'h0);
        setf(7'h7f, 8'hff);
        op(`OP_COMPLEMENT, `DEST_FILE, 7'h7f);
        cr(`OFS_FILE_DATA, 32'h0);
        cr(`OFS_STATUS, 32'h1);
        wr(`OFS_STATUS, 32'h0);
        setf(7'h00, 8'h33);
        op(`OP_CLEAR_REG, `DEST_ACCUM, 7'h00);
        cr(`OFS_FILE_DATA, 32'h0);
        cr(`OFS_ACCUM, 32'ha5);
        cr(`OFS_STATUS, 32'h1);
        wr(`OFS_STATUS, 32'h0);
        op(`OP_CLEAR_ACC, `DEST_ACCUM, 7'h00);
        cr(`OFS_ACCUM, 32'h0);
        cr(`OFS_STATUS, 32'h1);
        wr(`OFS_STATUS, 32'h0);
        setf(7'h00, 8'h01);
        wr(`OFS_ACCUM, 32'h77);
        op(`OP_DECREMENT, `DEST_ACCUM, 7'h00);
        cr(`OFS_ACCUM, 32'h0);
        cr(`OFS_STATUS, 32'h1);
        setf(7'h00, 8'h00);
        op(`OP_DECREMENT, `DEST_FILE, 7'h00);
        cr(`OFS_FILE_DATA, 32'hff);
        cr(`OFS_STATUS, 32'h0);
        // skip on zero: the discarded word must leave no trace
        wr(`OFS_PROG_COUNTER, 32'h100);
        setf(7'h05, 8'h02);
        op(`OP_DEC_SKIP, `DEST_FILE, 7'h05);
        cr(`OFS_FILE_DATA, 32'h1);
        cr(`OFS_STATUS, 32'h0);
        wr(`OFS_ACCUM, 32'h77);
        op(`OP_DEC_SKIP, `DEST_ACCUM, 7'h05);
        cr(`OFS_ACCUM, 32'h0);
        cr(`OFS_STATUS, 32'h2);
        op(`OP_CLEAR_REG, `DEST_ACCUM, 7'h05);
        cr(`OFS_FILE_DATA, 32'h1);
        cr(`OFS_STATUS, 32'h0);
        cr(`OFS_PROG_COUNTER, 32'h103);
        wr(`OFS_STATUS, 32'h1);
        setf(7'h05, 8'hfe);
        op(`OP_INC_SKIP, `DEST_FILE, 7'h05);
        cr(`OFS_FILE_DATA, 32'hff);
        cr(`OFS_STATUS, 32'h1);
        op(`OP_INC_SKIP, `DEST_FILE, 7'h05);
        cr(`OFS_FILE_DATA, 32'h0);
        cr(`OFS_STATUS, 32'h3);
        op(`OP_COMPLEMENT, `DEST_FILE, 7'h05);
        cr(`OFS_FILE_DATA, 32'h0);
        cr(`OFS_STATUS, 32'h1);
        for (int i = 0; i < 2; i++) begin
            wr(`OFS_STATUS, 32'h0);
            wr(`OFS_PAGE_LATCH, {27'h0, pg[i]});
            wr(`OFS_CYCLE_COUNT, 32'h0);
            wr(`OFS_INSTR, {16'h0, `OP_BRANCH, 1'b0, lit[i]});
            cr(`OFS_PROG_COUNTER, {19'h0, pg[i][4:3], lit[i]});
            cr(`OFS_CYCLE_COUNT, 32'h2);
            cr(`OFS_STATUS, 32'h2);
            op(`OP_CLEAR_ACC, `DEST_ACCUM, 7'h00);
            cr(`OFS_STATUS, 32'h0);
            cr(`OFS_CYCLE_COUNT, 32'h3);
        end
        summarize();
    end
endmodule
